// *** include/sbs_pkg.sv ***
// Shared constants for the synchronous burst static memory port.
// Assumes one clock domain and a 32-bit classic Wishbone slave port.
package sbs_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 18;
  localparam int DATA_W    = 16;
  localparam int LANES     = 2;
  localparam int LANE_BITS = 8;
  localparam int LANE_W    = LANE_BITS + 1;
  localparam int WORD_W    = LANES * LANE_W;
  localparam int BURST_W   = 2;

  // ----------------------------------------------------------------
  // Access states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_IDLE  = 3'h1,
    OP_READ  = 3'h2,
    OP_WRITE = 3'h4
  } sbs_op_t;

  // ----------------------------------------------------------------
  // Wishbone register map and fields
  // ----------------------------------------------------------------
  localparam int          WB_ADR_W       = 4;
  localparam logic [3:0]  CTRL_OFF       = 4'h0;
  localparam logic [3:0]  STAT_OFF       = 4'h4;
  localparam logic [3:0]  ADDR_OFF       = 4'h8;
  localparam int          CTRL_INH_BIT   = 0;
  localparam int          STAT_SEL_BIT   = 0;
  localparam int          STAT_ILV_BIT   = 1;
  localparam int          STAT_WPEND_BIT = 2;
  localparam int          STAT_DRIVE_BIT = 3;
  localparam logic        CTRL_INH_RST   = 1'b0;
  localparam logic        ILV_RST        = 1'b1;
  localparam logic [1:0]  CNT_RST        = 2'h0;

endpackage : sbs_pkg

// *** include/sbs_lane_if.sv ***
// Carrier between the port control and one byte-lane store.
// Assumes the store answers reads combinationally.
interface sbs_lane_if #(
  parameter int AW = 18,
  parameter int W  = 9
) ();
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0]  wr_data;
  logic [AW-1:0] rd_addr;
  logic [W-1:0]  rd_data;

  modport ctrl  (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : sbs_lane_if

// *** src/sbs_lane.sv ***
// One byte lane of the array: eight data bits and one parity bit.
// Assumes the write enable is already qualified by clock hold.
module sbs_lane #(
  parameter int AW = 18,
  parameter int W  = 9
) (
  input wire logic clock_i,
  sbs_lane_if.store bus
);

  logic [W-1:0] mem_reg [2**AW];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // The write completes at one edge with no external pulse timing.
  always_ff @(posedge clock_i) begin
    if (bus.wr_en) begin
      mem_reg[bus.wr_addr] <= bus.wr_data;
    end
  end

  // Data committed at this edge is forwarded to a read of the same word.
  assign bus.rd_data = (bus.wr_en && bus.wr_addr == bus.rd_addr) ? bus.wr_data : mem_reg[bus.rd_addr];

  write_commit_a: assert property (@(posedge clock_i)
    bus.wr_en |=> mem_reg[$past(bus.wr_addr)] == $past(bus.wr_data))
    else $error("Lane word differs from the data written.");

endmodule : sbs_lane

// *** src/sbs_top.sv ***
// Synchronous flow-through burst memory port with a Wishbone status port.
// Assumes all memory pins are synchronous to clock_i; the output enable
// pin is the only asynchronous term and gates the drivers directly.
//
// The Wishbone register port and the placing of the registers were decided locally.

module sbs_top #(
  parameter int ADDR_W = sbs_pkg::ADDR_W
) (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              chip_sel_a_n_i,
  input  wire logic              chip_sel_b_i,
  input  wire logic              chip_sel_c_n_i,
  input  wire logic              write_n_i,
  input  wire logic [1:0]        lane_write_sel_n_i,
  input  wire logic              burst_step_or_load_i,
  input  wire logic              clock_hold_n_i,
  input  wire logic              out_en_n_i,
  input  wire logic              burst_mode_i,
  input  wire logic [15:0]       dq_i,
  output      logic [15:0]       dq_o,
  output      logic              dq_oe_o,
  input  wire logic [1:0]        parity_lines_i,
  output      logic [1:0]        parity_lines_o,
  output      logic              parity_lines_oe_o,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output      logic [31:0]       wb_dat_o,
  output      logic              wb_ack_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int LW = sbs_pkg::LANE_W;
  localparam int LB = sbs_pkg::LANE_BITS;

  sbs_pkg::sbs_op_t    op_reg;
  sbs_pkg::sbs_op_t    op_next;
  logic [ADDR_W-1:0]   base_reg;
  logic [ADDR_W-1:0]   base_next;
  logic [1:0]          cnt_reg;
  logic [1:0]          cnt_next;
  logic [1:0]          low_bits;
  logic [ADDR_W-1:0]   eff_addr;
  logic                run;
  logic                load;
  logic                sel_in;
  logic                ilv_reg;
  logic                strap_done_reg;
  logic                wr_pend_reg;
  logic [1:0]          wr_lane_reg;
  logic [ADDR_W-1:0]   acc_addr_reg;
  logic                drive_reg;
  logic [15:0]         dq_reg;
  logic [1:0]          par_reg;
  logic [sbs_pkg::WORD_W-1:0] rd_word;
  logic                inhibit_reg;
  logic                wb_ack_reg;
  logic [31:0]         wb_dat_reg;
  logic [31:0]         wb_rd_word;
  logic                wb_req;

  // ----------------------------------------------------------------
  // Input qualification
  // ----------------------------------------------------------------
  // clock hold gating
  assign run    = !clock_hold_n_i;
  assign load   = !burst_step_or_load_i;
  assign sel_in = !chip_sel_a_n_i && chip_sel_b_i && !chip_sel_c_n_i;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // strap caught after reset
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ilv_reg        <= sbs_pkg::ILV_RST;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      ilv_reg        <= burst_mode_i;
      strap_done_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Command decode and burst counter
  // ----------------------------------------------------------------
  // Works out the access that the coming edge will capture.
  always_comb begin
    op_next   = op_reg;
    base_next = base_reg;
    cnt_next  = cnt_reg;
    if (load) begin
      base_next = addr_i;
      cnt_next  = sbs_pkg::CNT_RST;
      if (sel_in) begin
        op_next = write_n_i ? sbs_pkg::OP_READ : sbs_pkg::OP_WRITE;
      end else begin
        op_next = sbs_pkg::OP_IDLE;
      end
    end else begin
      case (op_reg)
        sbs_pkg::OP_IDLE: begin
          op_next = sbs_pkg::OP_IDLE; // A step while deselected stays idle.
        end
        sbs_pkg::OP_READ, sbs_pkg::OP_WRITE: begin
          cnt_next = cnt_reg + 2'h1;
        end
        default: begin
          op_next = sbs_pkg::OP_IDLE;
        end
      endcase
    end
  end

  assign low_bits = ilv_reg ? (base_next[1:0] ^ cnt_next) : (base_next[1:0] + cnt_next);
  assign eff_addr = {base_next[ADDR_W-1:2], low_bits};

  // Burst state; inputs registered, frozen under hold.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      op_reg   <= sbs_pkg::OP_IDLE;
      base_reg <= '0;
      cnt_reg  <= sbs_pkg::CNT_RST;
    end else if (run) begin
      op_reg   <= op_next;
      base_reg <= base_next;
      cnt_reg  <= cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Write stage
  // ----------------------------------------------------------------
  // data one edge later
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_pend_reg  <= 1'b0;
      wr_lane_reg  <= 2'h0;
      acc_addr_reg <= '0;
    end else if (run) begin
      wr_pend_reg  <= (op_next == sbs_pkg::OP_WRITE);
      wr_lane_reg  <= (op_next == sbs_pkg::OP_WRITE) ? ~lane_write_sel_n_i : 2'h0;
      acc_addr_reg <= eff_addr;
    end
  end

  // ----------------------------------------------------------------
  // Byte lanes
  // ----------------------------------------------------------------
  // two nine-bit lanes
  for (genvar k = 0; k < sbs_pkg::LANES; k++) begin : g_lane
    sbs_lane_if #(.AW(ADDR_W), .W(LW)) lane_bus ();

    assign lane_bus.wr_en   = run && wr_pend_reg && wr_lane_reg[k];
    assign lane_bus.wr_addr = acc_addr_reg;
    assign lane_bus.wr_data = {parity_lines_i[k], dq_i[k*LB +: LB]};
    assign lane_bus.rd_addr = eff_addr;
    assign rd_word[k*LW +: LW] = lane_bus.rd_data;

    sbs_lane #(
      .AW (ADDR_W),
      .W  (LW)
    ) u_lane (
      .clock_i (clock_i),
      .bus     (lane_bus)
    );
  end

  // ----------------------------------------------------------------
  // Read data and driver control
  // ----------------------------------------------------------------
  // data of captured address
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dq_reg  <= 16'h0000;
      par_reg <= 2'h0;
    end else if (run && op_next == sbs_pkg::OP_READ) begin
      dq_reg  <= {rd_word[LW +: LB], rd_word[0 +: LB]};
      par_reg <= {rd_word[2*LW-1], rd_word[LW-1]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      drive_reg <= 1'b0;
    end else if (run) begin
      drive_reg <= (op_next == sbs_pkg::OP_READ) && (op_reg != sbs_pkg::OP_IDLE) && !inhibit_reg;
    end
  end

  assign dq_o           = dq_reg;
  assign parity_lines_o = par_reg;
  assign dq_oe_o           = drive_reg && !out_en_n_i;
  assign parity_lines_oe_o = drive_reg && !out_en_n_i;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_reg;

  // Read decode; unmapped offsets read as zero.
  always_comb begin
    wb_rd_word = 32'h0000_0000;
    if (wb_adr_i == sbs_pkg::CTRL_OFF) begin
      wb_rd_word[sbs_pkg::CTRL_INH_BIT] = inhibit_reg;
    end else if (wb_adr_i == sbs_pkg::STAT_OFF) begin
      wb_rd_word[sbs_pkg::STAT_SEL_BIT]   = (op_reg != sbs_pkg::OP_IDLE);
      wb_rd_word[sbs_pkg::STAT_ILV_BIT]   = ilv_reg;
      wb_rd_word[sbs_pkg::STAT_WPEND_BIT] = wr_pend_reg;
      wb_rd_word[sbs_pkg::STAT_DRIVE_BIT] = drive_reg;
    end else if (wb_adr_i == sbs_pkg::ADDR_OFF) begin
      wb_rd_word[ADDR_W-1:0] = acc_addr_reg;
    end
  end

  // Ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
    end else begin
      wb_ack_reg <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_reg <= wb_rd_word;
      end
    end
  end

  // Control register; the inhibit bit keeps the drivers off from the next edge not under clock hold.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      inhibit_reg <= sbs_pkg::CTRL_INH_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == sbs_pkg::CTRL_OFF) begin
      inhibit_reg <= wb_dat_i[sbs_pkg::CTRL_INH_BIT];
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // hold freezes state
  hold_freeze_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    clock_hold_n_i |=> $stable(op_reg) && $stable(base_reg) && $stable(cnt_reg) && $stable(dq_reg))
    else $error("State changed while clock hold was high.");

  write_hiz_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    run && op_next == sbs_pkg::OP_WRITE |=> !dq_oe_o && !parity_lines_oe_o)
    else $error("Data drivers on during a write data phase.");

  desel_hiz_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    run && op_reg == sbs_pkg::OP_IDLE |=> !drive_reg)
    else $error("Drivers on in the first clock after deselect.");

  sel_decode_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    run && load && !(!chip_sel_a_n_i && chip_sel_b_i && !chip_sel_c_n_i) |=> op_reg == sbs_pkg::OP_IDLE)
    else $error("Device selected with a wrong chip select pattern.");

  step_count_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    run && !load && op_reg != sbs_pkg::OP_IDLE |=> cnt_reg == $past(cnt_reg) + 2'h1)
    else $error("Burst counter did not advance by one.");

  load_addr_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    run && load |=> base_reg == $past(addr_i) && cnt_reg == sbs_pkg::CNT_RST)
    else $error("Load did not take the address inputs.");

  write_pend_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    run && op_next == sbs_pkg::OP_WRITE ##1 clock_hold_n_i [*2] |-> wr_pend_reg)
    else $error("Pending write lost while clock was held.");

  turn_drive_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    run && op_reg == sbs_pkg::OP_WRITE && op_next == sbs_pkg::OP_READ && !inhibit_reg |=> drive_reg)
    else $error("Read after write was not driven at once.");

  wrap_lin_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !ilv_reg && run && !load && op_reg != sbs_pkg::OP_IDLE && cnt_reg == 2'h3
    |=> acc_addr_reg[ADDR_W-1:2] == $past(base_reg[ADDR_W-1:2]) && acc_addr_reg[1:0] == $past(base_reg[1:0]))
    else $error("Linear burst left its four-word group.");

endmodule : sbs_top

// *** tb/sbs_ctl_model.sv ***
// Memory controller model that drives the synchronous memory pins.
// Assumes the bench steps it once per clock through the beat task.
module sbs_ctl_model #(
  parameter int AW = 6
) (
  input  wire logic          clock_i,
  output      logic [AW-1:0] addr_o,
  output      logic [2:0]    sel_o,
  output      logic          write_n_o,
  output      logic [1:0]    lane_n_o,
  output      logic          step_o,
  output      logic          hold_o,
  output      logic [15:0]   dq_o,
  output      logic [1:0]    par_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Command and data beats
  // ------------------------------------------------------------
  logic        drv_q = 1'b0;
  logic [17:0] dat_q = 18'h0;
  logic [17:0] bus_q = 18'h0;

  // Lines start deselected, running and loading.
  initial begin
    {addr_o, write_n_o, lane_n_o, step_o, hold_o} = '0;
    sel_o = 3'h4;
  end

  // The data lines carry one word, parity bits inside each lane.
  assign {par_o[1], dq_o[15:8], par_o[0], dq_o[7:0]} = bus_q;

  // One clock of traffic, issued just after a rising edge.
  task automatic beat(input logic h, st, w, input logic [2:0] s, input logic [AW-1:0] a,
                      input logic [1:0] ln, input logic [17:0] wd);
    @(posedge clock_i);
    hold_o   <= h;
    step_o   <= st;
    sel_o    <= s;
    addr_o   <= a;
    lane_n_o <= ln;
    write_n_o <= ~w;
    bus_q <= drv_q ? dat_q : ~bus_q;
    if (!h) begin
      drv_q = w;
      dat_q = wd;
    end
  endtask : beat
endmodule : sbs_ctl_model

// *** tb/tb.sv ***
// Self-checking bench for the burst memory port and its status port.
// Assumes the controller model in sbs_ctl_model and a small address width.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int         AW  = 6;
  localparam logic [2:0] SEL = 3'h2;

  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              oe_n  = 1'b0;
  logic              mode  = 1'b1;
  logic              cyc   = 1'b0;
  logic              stb   = 1'b0;
  logic              wwe   = 1'b0;
  logic [3:0]        adr   = 4'h0;
  logic [3:0]        wsel  = 4'h0;
  logic [31:0]       wdat  = 32'h0;
  logic [31:0]       wq;
  logic              ack;
  logic [15:0]       dq_r, dq_w, m_dq;
  logic [1:0]        par_r, par_w, m_par, m_ln;
  logic              dq_oe, par_oe, m_wn, m_step, m_hold;
  logic [2:0]        m_sel;
  logic [AW-1:0]     m_addr;
  logic [17:0]       rdw;
  logic [17:0]       mem [0:63];
  logic [31:0]       q;
  int                fail_count = 0;
  int                num_checks = 0;
  int                cyc_n = 0;
  logic [2:0]        bad [0:2] = '{3'h6, 3'h0, 3'h3};

  // Clock at 40 MHz.
  initial begin
    forever #12.5 clock = ~clock;
  end

  // Wire levels follow whichever side enables its drivers.
  assign dq_w  = dq_oe ? dq_r : m_dq;
  assign par_w = par_oe ? par_r : m_par;
  assign rdw   = {par_r[1], dq_r[15:8], par_r[0], dq_r[7:0]};

  sbs_top #(.ADDR_W(AW)) sbs_top_i (
    .clock_i(clock), .rst_n_i(rst_n), .addr_i(m_addr), .chip_sel_a_n_i(m_sel[2]),
    .chip_sel_b_i(m_sel[1]), .chip_sel_c_n_i(m_sel[0]), .write_n_i(m_wn),
    .lane_write_sel_n_i(m_ln), .burst_step_or_load_i(m_step), .clock_hold_n_i(m_hold),
    .out_en_n_i(oe_n), .burst_mode_i(mode), .dq_i(dq_w), .dq_o(dq_r), .dq_oe_o(dq_oe),
    .parity_lines_i(par_w), .parity_lines_o(par_r), .parity_lines_oe_o(par_oe),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(wsel), .wb_dat_o(wq), .wb_ack_o(ack));

  sbs_ctl_model #(.AW(AW)) sbs_ctl_model_i (
    .clock_i(clock), .addr_o(m_addr), .sel_o(m_sel), .write_n_o(m_wn), .lane_n_o(m_ln),
    .step_o(m_step), .hold_o(m_hold), .dq_o(m_dq), .par_o(m_par));

  // ------------------------------------------------------------
  // Compare, access and closing tasks
  // ------------------------------------------------------------
  task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_d

  task automatic chk_f(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_f

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // One beat; outputs are looked at once that edge's updates landed.
  task automatic b(input logic h, st, w, input logic [2:0] s, input logic [AW-1:0] a,
                   input logic [1:0] ln, input logic [17:0] wd);
    sbs_ctl_model_i.beat(h, st, w, s, a, ln, wd);
    #1;
  endtask : b

  task automatic wr(input logic [AW-1:0] a, input logic [1:0] ln, input logic [17:0] d);
    b(1'b0, 1'b0, 1'b1, SEL, a, ln, d);
    if (!ln[0]) mem[a][8:0] = d[8:0];
    if (!ln[1]) mem[a][17:9] = d[17:9];
  endtask : wr

  // Classic single Wishbone cycle, held until ack is sampled high.
  // Only the bench's cycle ceiling ends a wait that never sees ack.
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    {cyc, stb, wwe, adr, wdat, wsel} <= {2'h3, we, a, d, 4'hf};
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = wq;
    {cyc, stb} <= 2'h0;
  endtask : wb

  // Reset is driven on an edge; drivers are looked at once settled.
  task automatic do_reset(input logic md);
    @(posedge clock);
    mode  <= md;
    rst_n <= 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    #1 chk_f(dq_oe, 1'b0);
    repeat (2) @(posedge clock);
  endtask : do_reset

  // Load at word 5, step with one held edge; expected order per strap.
  task automatic burst(input logic md);
    do_reset(md);
    b(0, 0, 0, SEL, 6'h5, 2'h0, 18'h0);
    b(0, 1, 0, SEL, 6'h0, 2'h0, 18'h0);
    chk_d(rdw, mem[5]);
    chk_f(dq_oe, 1'b0);
    b(1, 1, 0, SEL, 6'h0, 2'h0, 18'h0);
    chk_d(rdw, mem[md ? 4 : 6]);
    b(0, 1, 0, SEL, 6'h0, 2'h0, 18'h0);
    chk_d(rdw, mem[md ? 4 : 6]);
    b(0, 1, 0, SEL, 6'h0, 2'h0, 18'h0);
    chk_d(rdw, mem[md ? 7 : 7]);
    b(0, 1, 0, SEL, 6'h0, 2'h0, 18'h0);
    chk_d(rdw, mem[md ? 6 : 4]);
    b(0, 0, 0, 3'h4, 6'h0, 2'h0, 18'h0);
    chk_d(rdw, mem[5]);
    $display("burst test done, mode %0d", md);
  endtask : burst

  // Cycle ceiling cuts a hang short.
  always @(posedge clock) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      fail_count++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset(1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(6'(4 + i), 2'h0, 18'(18'h2a5a5 ^ (18'h1111 * i)));
      if (i > 0) chk_f(dq_oe, 1'b0);
    end
    b(0, 0, 0, SEL, 6'h7, 2'h0, 18'h0);
    b(0, 0, 0, SEL, 6'h4, 2'h0, 18'h0);
    chk_d(rdw, mem[7]);
    chk_f(dq_oe, 1'b1);
    // The read captured as the write is issued still shows the old word.
    q = 32'(mem[4]);
    wr(6'h4, 2'h2, 18'h3ffff);
    chk_d(rdw, q);
    b(1, 0, 0, SEL, 6'h4, 2'h0, 18'h0);
    chk_f(dq_oe, 1'b0);
    b(1, 0, 0, SEL, 6'h4, 2'h0, 18'h0);
    chk_d(rdw, q);
    b(0, 0, 0, SEL, 6'h4, 2'h0, 18'h0);
    chk_f(dq_oe, 1'b0);
    b(0, 0, 0, 3'h4, 6'h0, 2'h0, 18'h0);
    chk_d(rdw, mem[4]);
    $display("write and read test done");
    burst(1'b0);
    burst(1'b1);
    for (int k = 0; k < 3; k++) begin
      b(0, 0, 0, bad[k], 6'h4, 2'h0, 18'h0);
      b(0, 0, 0, SEL, 6'h4, 2'h0, 18'h0);
      chk_f(dq_oe, 1'b0);
      b(0, 0, 0, SEL, 6'h4, 2'h0, 18'h0);
      chk_f(dq_oe, 1'b0);
      chk_d(rdw, mem[4]);
      b(0, 0, 0, SEL, 6'h4, 2'h0, 18'h0);
      chk_f(dq_oe, 1'b1);
    end
    @(posedge clock);
    oe_n <= 1'b1;
    #1 chk_f(par_oe, 1'b0);
    @(posedge clock);
    oe_n <= 1'b0;
    #1 chk_f(dq_oe, 1'b1);
    $display("select test done");
    wb(1'b1, sbs_pkg::CTRL_OFF, 32'h1);
    #1 chk_f(dq_oe, 1'b0);
    chk_f(ack, 1'b0);
    wb(1'b0, sbs_pkg::CTRL_OFF, 32'h0);
    chk_d(q, 32'h1);
    wb(1'b0, sbs_pkg::STAT_OFF, 32'h0);
    chk_d(q, 32'h3);
    wb(1'b0, sbs_pkg::ADDR_OFF, 32'h0);
    chk_d(q, 32'h4);
    wb(1'b0, 4'hc, 32'h0);
    chk_d(q, 32'h0);
    $display("status port test done");
    end_sim();
  end
endmodule : tb
